// *** asc_pkg.sv ***
// Package with register map, field positions and timing constants of the sequencer.
package asc_pkg;
  localparam int          ADDR_W           = 16;
  localparam int          DATA_W           = 8;
  localparam logic [15:0] CTL_OFFSET       = 16'h1030;
  localparam logic [15:0] RES1_OFFSET      = 16'h1031;
  localparam logic [15:0] RES2_OFFSET      = 16'h1032;
  localparam logic [15:0] RES3_OFFSET      = 16'h1033;
  localparam logic [15:0] RES4_OFFSET      = 16'h1034;
  localparam logic [15:0] IRQ_STAT_OFFSET  = 16'h1035;
  localparam logic [15:0] IRQ_MASK_OFFSET  = 16'h1036;
  localparam int          DONE_BIT         = 7;
  localparam int          UNUSED_BIT       = 6;
  localparam int          SCAN_BIT         = 5;
  localparam int          GROUP_BIT        = 4;
  localparam logic [7:0]  CTL_RESET        = 8'h80;
  localparam logic [7:0]  RESULT_RESET     = 8'h00;
  localparam logic [1:0]  IRQ_RESET        = 2'h0;
  localparam int          IRQ_DONE_BIT     = 0;
  localparam int          IRQ_CONV_BIT     = 1;
  localparam real         CLOCK_MHZ        = 250.0;
  localparam real         STOP_SETTLE_MS   = 10.0;
  localparam int          STOP_SETTLE_CYC  = int'(STOP_SETTLE_MS * 1000.0 * CLOCK_MHZ);
  localparam int          SAR_BITS         = 8;
  localparam logic [2:0]  DONE_GUARD_CYC   = 3'h4;

  typedef enum logic [3:0] {
    ASC_IDLE    = 4'b0001,
    ASC_REQUEST = 4'b0010,
    ASC_WAIT    = 4'b0100,
    ASC_HOLD    = 4'b1000
  } asc_state_type;
endpackage : asc_pkg

// *** asc_sequencer.sv ***
// Digital sequencer for a four-conversion successive-approximation converter.
// How it works
// - Single channel, no repeat: four results, stop.
// - Single channel, repeat: overwrite slots cyclically forever.
// - Group mode, no repeat: four channels once.
// - Group mode, repeat: cycle group, fixed slots.
// - Low-power mode suspends; resume resamples current channel.
// - Bit 7 read-only flag, bit 6 zero.
// - Control write aborts and restarts sequence.
// - Control write clears the completion flag.
// - Flag set after four valid results, stays.
// - Single channel taken from bits 3 to 0.
// - Group mode uses upper bits, slot from low.
// - Channel codes select inputs, references, test points.
// - Four read-only eight-bit result registers.
// - Result writes change nothing.
// - First request on convert_out two cycles after the write.
// - Trial starts at MSB, core result moved to slot.
//
// The implementer's own choice: the address-and-strobe port.
module asc_sequencer
  import asc_pkg::*;
(
  // Clock and reset.
  input  wire logic                       clock_in,
  input  wire logic                       rst_in,
  // Register port.
  input  wire logic [asc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [asc_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       write_in,
  input  wire logic                       read_in,
  output logic      [asc_pkg::DATA_W-1:0] rdata_out,
  // Low-power mode indication from the processor.
  input  wire logic                       low_power_in,
  // Analog core handshake.
  output logic      [3:0]                 channel_out,
  output logic                            convert_out,
  input  wire logic                       compare_in,
  output logic      [7:0]                 trial_out,
  input  wire logic                       core_done_in,
  input  wire logic [7:0]                 core_result_in,
  // Interrupt.
  output logic                            irq_out
);
  import asc_pkg::*;

  // The done and low-power inputs are asynchronous, so they pass three flops; the comparator input is not synchronised.
  logic [2:0]    done_sync;
  logic [2:0]    next_done_sync;
  logic [2:0]    low_sync;
  logic [2:0]    next_low_sync;
  logic          done_seen;
  logic          next_done_seen;
  logic          low_seen;
  logic          next_low_seen;
  logic          done_rise;

  always_comb begin
    next_done_sync = {done_sync[1:0], core_done_in};
    next_low_sync  = {low_sync[1:0], low_power_in};
    next_done_seen = done_seen;
    next_low_seen  = low_seen;
    if (done_sync[1] == done_sync[2]) begin
      next_done_seen = done_sync[2];
    end
    if (low_sync[1] == low_sync[2]) begin
      next_low_seen = low_sync[2];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      done_sync <= 3'h0;
      low_sync  <= 3'h0;
      done_seen <= 1'b0;
      low_seen  <= 1'b0;
    end else begin
      done_sync <= next_done_sync;
      low_sync  <= next_low_sync;
      done_seen <= next_done_seen;
      low_seen  <= next_low_seen;
    end
  end

  assign done_rise = next_done_seen && !done_seen;

  // Channel selection for a given slot.
  function automatic logic [3:0] slot_channel(input logic [3:0] sel, input logic group,
                                              input logic [1:0] slot);
    if (group) begin
      slot_channel = {sel[3:2], slot};
    end else begin
      slot_channel = sel;
    end
  endfunction

  // Sequencer state.
  asc_state_type state;
  asc_state_type next_state;
  logic [5:0]    ctl;
  logic [5:0]    next_ctl;
  logic          done_flag;
  logic          next_done_flag;
  logic [1:0]    slot;
  logic [1:0]    next_slot;
  logic [7:0]    results [4];
  logic [7:0]    next_results [4];
  logic [3:0]    channel;
  logic [3:0]    next_channel;
  logic          convert;
  logic          next_convert;
  logic [7:0]    sar;
  logic [7:0]    next_sar;
  logic          done_event;
  logic          conv_event;
  logic          ctl_write;
  logic          suspended;
  logic          next_suspended;
  logic [2:0]    guard;
  logic [2:0]    next_guard;

  assign ctl_write = write_in && (addr_in == CTL_OFFSET);

  always_comb begin
    next_state     = state;
    next_ctl       = ctl;
    next_done_flag = done_flag;
    next_slot      = slot;
    next_results   = results;
    next_channel   = channel;
    next_convert   = 1'b0;
    next_sar       = sar;
    next_suspended = suspended;
    done_event     = 1'b0;
    conv_event     = 1'b0;
    if (ctl_write) begin
      // Only writes to the control register reach the sequencer state; result writes fall through.
      next_ctl       = {wdata_in[SCAN_BIT], wdata_in[GROUP_BIT], wdata_in[3:0]};
      next_done_flag = 1'b0;
      next_slot      = 2'h0;
      next_state     = ASC_REQUEST;
      next_suspended = 1'b0;
    end else begin
      case (state)
        ASC_IDLE: begin
          next_state = ASC_IDLE;
        end
        ASC_REQUEST: begin
          if (low_seen) begin
            next_state = ASC_HOLD;
          end else begin
            next_channel = slot_channel(ctl[3:0], ctl[4], slot);
            next_convert = 1'b1;
            next_sar     = 8'h80;
            next_state   = ASC_WAIT;
          end
        end
        ASC_WAIT: begin
          if (low_seen) begin
            // The partial conversion is dropped; resuming samples the channel afresh.
            next_state = ASC_HOLD;
          end else if (done_rise && (guard == 3'h0)) begin
            next_results[slot] = core_result_in;
            next_sar           = core_result_in;
            next_slot          = slot + 2'h1;
            conv_event         = 1'b1;
            if (slot == 2'h3) begin
              if (!done_flag) begin
                done_event = 1'b1;
              end
              next_done_flag = 1'b1;
              next_state     = ctl[5] ? ASC_REQUEST : ASC_IDLE;
            end else begin
              next_state = ASC_REQUEST;
            end
          end
        end
        ASC_HOLD: begin
          next_suspended = 1'b1;
          if (!low_seen) begin
            next_suspended = 1'b0;
            next_state     = ASC_REQUEST;
          end
        end
        default: begin
          next_state = ASC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state     <= ASC_IDLE;
      ctl       <= CTL_RESET[5:0];
      done_flag <= CTL_RESET[DONE_BIT];
      slot      <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        results[i] <= RESULT_RESET;
      end
      channel   <= 4'h0;
      convert   <= 1'b0;
      sar       <= 8'h00;
      suspended <= 1'b0;
    end else begin
      state     <= next_state;
      ctl       <= next_ctl;
      done_flag <= next_done_flag;
      slot      <= next_slot;
      results   <= next_results;
      channel   <= next_channel;
      convert   <= next_convert;
      sar       <= next_sar;
      suspended <= next_suspended;
    end
  end

  // A done edge left over from an aborted conversion can still cross the synchroniser
  // just after a restart, so done edges are ignored for a few cycles after each request.
  always_comb begin
    next_guard = guard;
    if (next_convert) begin
      next_guard = DONE_GUARD_CYC;
    end else if (guard != 3'h0) begin
      next_guard = guard - 3'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      guard <= 3'h0;
    end else begin
      guard <= next_guard;
    end
  end

  // Interrupt status and mask.
  logic [1:0] irq_stat;
  logic [1:0] next_irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic       next_irq;

  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (read_in && (addr_in == IRQ_STAT_OFFSET)) begin
      next_irq_stat = 2'h0;
    end
    // A new event in the clearing cycle wins over the read clear.
    if (done_event) begin
      next_irq_stat[IRQ_DONE_BIT] = 1'b1;
    end
    if (conv_event) begin
      next_irq_stat[IRQ_CONV_BIT] = 1'b1;
    end
    if (write_in && (addr_in == IRQ_MASK_OFFSET)) begin
      next_irq_mask = wdata_in[1:0];
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      irq_out  <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq_out  <= next_irq;
    end
  end

  // Read data, valid only in the cycle after the read strobe.
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (read_in) begin
      case (addr_in)
        CTL_OFFSET:      next_rdata = {done_flag, 1'b0, ctl};
        RES1_OFFSET:     next_rdata = results[0];
        RES2_OFFSET:     next_rdata = results[1];
        RES3_OFFSET:     next_rdata = results[2];
        RES4_OFFSET:     next_rdata = results[3];
        IRQ_STAT_OFFSET: next_rdata = {6'h00, irq_stat};
        IRQ_MASK_OFFSET: next_rdata = {6'h00, irq_mask};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_out   <= 8'h00;
      channel_out <= 4'h0;
      convert_out <= 1'b0;
      trial_out   <= 8'h00;
    end else begin
      rdata_out   <= next_rdata;
      channel_out <= next_channel;
      convert_out <= next_convert;
      trial_out   <= next_sar;
    end
  end

  // The comparator bit is reserved for a core that needs per-bit trials; unused here.
  logic unused_compare;
  assign unused_compare = compare_in ^ suspended;
endmodule : asc_sequencer

// *** asc_sequencer_assertions.sv ***
// Port checker for the conversion sequencer.
module asc_sequencer_checker
  import asc_pkg::*;
(
  // Clock, reset and register port.
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        write_in,
  input wire logic        read_in,
  input wire logic [7:0]  rdata_out,
  // Low-power input and analog core side.
  input wire logic        low_power_in,
  input wire logic [3:0]  channel_out,
  input wire logic        convert_out,
  input wire logic [7:0]  trial_out,
  input wire logic        core_done_in,
  input wire logic [7:0]  core_result_in
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  logic wr_ctl;
  assign wr_ctl = write_in && addr_in == CTL_OFFSET;
  sequence start_s;
    ##2 convert_out;
  endsequence
  sequence done_s;
    $rose(core_done_in) ##1 (core_done_in && !low_power_in && !convert_out && !wr_ctl) [*3];
  endsequence
  AST_START: assert property (wr_ctl |-> start_s)
    else $error("no request two cycles after a control write");
  AST_SINGLE: assert property (wr_ctl && !wdata_in[GROUP_BIT] |-> start_s ##0
    channel_out == $past(wdata_in[3:0], 2)) else $error("wrong single channel");
  AST_GROUP: assert property (wr_ctl && wdata_in[GROUP_BIT] |-> start_s ##0
    channel_out == {$past(wdata_in[3:2], 2), 2'b00}) else $error("wrong group channel");
  AST_PULSE: assert property (convert_out |=> !convert_out)
    else $error("request longer than one cycle");
  AST_MSB: assert property (convert_out |-> trial_out == 8'h80)
    else $error("trial does not start at the top bit");
  AST_CAPTURE: assert property (done_s |-> ##[1:3] trial_out == core_result_in)
    else $error("result not captured after done");
  AST_CHAN: assert property ($changed(channel_out) |-> convert_out)
    else $error("channel moved without a request");
  AST_BIT6: assert property (read_in && addr_in == CTL_OFFSET |=> !rdata_out[UNUSED_BIT])
    else $error("unused control bit read as one");
endmodule // asc_sequencer_checker
bind asc_sequencer asc_sequencer_checker chk_u (.clock_in, .rst_in, .addr_in, .wdata_in,
  .write_in, .read_in, .rdata_out, .low_power_in, .channel_out, .convert_out, .trial_out,
  .core_done_in, .core_result_in);

// *** asc_core_model.sv ***
// Behavioural model of the analog core behind the sequencer.
module asc_core_model (
  // Clock, reset and requests.
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] channel_out,
  input  wire logic       convert_out,
  input  wire logic [7:0] trial_out,
  // Answers.
  output logic            core_done_in,
  output logic      [7:0] core_result_in,
  output logic            compare_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt;
  logic [7:0] n;
  logic [7:0] val;
  assign compare_in = trial_out[7] ^ channel_out[0];
  // Released result lines show the inverse, so a late capture is caught.
  assign core_result_in = core_done_in ? val : ~val;
  // A new request restarts the core, so a conversion aborted by a new request never answers.
  always @(posedge clock_in) begin
    if (rst_in) begin
      cnt <= 0;
      n <= 8'h00;
      val <= 8'h00;
      core_done_in <= 1'b0;
    end else if (convert_out) begin
      cnt <= 16;
      n <= n + 8'h01;
      val <= {channel_out, n[3:0]};
      core_done_in <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      core_done_in <= cnt < 10 && cnt > 1;
    end
  end
endmodule // asc_core_model

// *** testbench.sv ***
// Self-checking bench for the conversion sequencer.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  wdata_in = 8'h00;
  logic        write_in = 1'b0;
  logic        read_in = 1'b0;
  logic        low_power_in = 1'b0;
  logic [7:0]  rdata_out, trial_out, core_result_in, q, n0, d;
  logic [3:0]  channel_out;
  logic        convert_out, compare_in, core_done_in, irq_out;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #2 clock_in = ~clock_in;
  asc_sequencer dut_u (.clock_in, .rst_in, .addr_in, .wdata_in, .write_in, .read_in,
    .rdata_out, .low_power_in, .channel_out, .convert_out, .compare_in, .trial_out,
    .core_done_in, .core_result_in, .irq_out);
  asc_core_model core_u (.clock_in, .rst_in, .channel_out, .convert_out, .trial_out,
    .core_done_in, .core_result_in, .compare_in);
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A hung handshake must not stall the run.
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= v;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clock_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1 q = rdata_out;
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    chk(q, e);
  endtask
  function automatic logic [7:0] expv(input logic [7:0] c, input int k, input logic [7:0] b);
    return {c[4] ? {c[3:2], 2'(k)} : c[3:0], 4'(b + 8'(k))};
  endfunction
  task automatic run(input logic [7:0] c);
    n0 = core_u.n;
    wr(CTL_OFFSET, c);
    rc(CTL_OFFSET, c);
    for (int i = 0; i < 100 && q[DONE_BIT] !== 1'b1; i++) rd(CTL_OFFSET);
    chk(q, c | 8'h80);
    for (int k = 0; k < 4; k++) rc(RES1_OFFSET + 16'(k), expv(c, k, n0));
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rc(CTL_OFFSET, CTL_RESET);
    rc(16'h1040, 8'h00);
    wr(IRQ_MASK_OFFSET, 8'h01);
    q = 8'h00;
    run(8'h03);
    chk({7'h00, irq_out}, 8'h01);
    rc(IRQ_STAT_OFFSET, 8'h03);
    @(posedge clock_in);
    #1 chk({7'h00, irq_out}, 8'h00);
    wr(RES2_OFFSET, 8'h5a);
    repeat (40) @(posedge clock_in);
    chk(core_u.n, n0 + 8'd4);
    rc(RES2_OFFSET, expv(8'h03, 1, n0));
    wr(IRQ_MASK_OFFSET, 8'h00);
    for (int c = 0; c < 32; c++) begin
      q = 8'h00;
      run(8'(c));
    end
    chk({7'h00, irq_out}, 8'h00);
    for (int s = 0; s < 2; s++) begin
      d = s ? 8'h34 : 8'h25;
      wr(CTL_OFFSET, d);
      // The aborted sequence may still count one request, so sample after it.
      repeat (2) @(posedge clock_in);
      n0 = core_u.n;
      while (core_u.n != n0 + 8'd7) @(posedge clock_in);
      rc(RES1_OFFSET, expv(d, 0, n0 + 8'd4));
      rc(RES2_OFFSET, expv(d, 1, n0 + 8'd4));
      rc(CTL_OFFSET, d | 8'h80);
    end
    while (convert_out !== 1'b1) @(posedge clock_in);
    wr(CTL_OFFSET, 8'h01);
    rc(CTL_OFFSET, 8'h01);
    q = 8'h00;
    run(8'h02);
    // Low power here stands for wait mode, so no settling pause follows.
    n0 = core_u.n + 8'd1;
    wr(CTL_OFFSET, 8'h06);
    low_power_in <= 1'b1;
    repeat (30) @(posedge clock_in);
    low_power_in <= 1'b0;
    repeat (120) @(posedge clock_in);
    for (int k = 0; k < 4; k++) rc(RES1_OFFSET + 16'(k), expv(8'h06, k, n0));
    chk(core_u.n, n0 + 8'd4);
    stop_test();
  end
endmodule // testbench
